// ==== hdl/gpdr_params.svh ====
// Register offsets, field masks, reset values and bus codes of the GPIO ports.
`ifndef GPDR_PARAMS_SVH
`define GPDR_PARAMS_SVH

// ************************************************************
// Address map
// ************************************************************
`define GPDR_BASE 32'h5002_0000
`define GPDR_REGION_MASK 32'hFFFF_FC00
`define GPDR_PORT_LSB 8
`define GPDR_OFF_DATA 8'h00
`define GPDR_OFF_DIR 8'h04
`define GPDR_OFF_SETCLR 8'h08
`define GPDR_OFF_DEBOUNCE 8'h0C
`define GPDR_OFF_POLARITY 8'h10
`define GPDR_OFF_SENSE 8'h14
`define GPDR_OFF_IRQ_EN 8'h18
`define GPDR_OFF_IRQ_DIS 8'h1C
`define GPDR_OFF_MASK_STAT 8'h20
`define GPDR_OFF_RAW_STAT 8'h24
`define GPDR_OFF_MSK_CLR 8'h28
`define GPDR_OFF_PULL 8'h30
`define GPDR_OFF_OTYPE 8'h34
`define GPDR_OFF_AF_LOW 8'h38
`define GPDR_OFF_AF_HIGH 8'h3C
`define GPDR_OFF_ADC_TRIG 8'h40

// ************************************************************
// Reset values and writable masks
// ************************************************************
`define GPDR_DATA_RST 16'hFFFF
`define GPDR_DIR_RST 16'hFFFF
`define GPDR_CFG_RST 32'h0000_0000
`define GPDR_DEBOUNCE_WMASK 32'hFFFF_FF07
`define GPDR_SENSE_WMASK 32'h0000_FFFF
`define GPDR_FULL_WMASK 32'hFFFF_FFFF

// ************************************************************
// Bus response codes
// ************************************************************
`define GPDR_RESP_OKAY 2'h0
`define GPDR_RESP_DECERR 2'h3

`endif

// ==== hdl/gpdr_pkg.sv ====
// Types shared by the GPIO port register block.
package gpdr_pkg;

  // ************************************************************
  // Held write request
  // ************************************************************
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } gpdr_wreq_t;

endpackage

// ==== hdl/gpdr_port_regs.sv ====
// Four 16-pin GPIO ports with their register file behind AXI4-Lite.
//
// Behaviour
// - four ports, bases 0x100 apart, base plus offset
// - data register drives output pins
// - data read returns sampled input pins
// - data register resets to all ones
// - upper data and direction bits read zero
// - direction bit zero output, resets input
// - upper set/clear bit clears data bit
// - lower set/clear bit sets data bit
// - set/clear bits self-clear after one cycle
// - zero set/clear bits leave data unchanged
// - set and clear together means clear
// - set/clear write-only, reads zero
// - interrupt enable write-only, reads zero
// - interrupt disable write-only, reads zero
// - mask and raw status read-only, reset zero
// - masked status readable, write one clears
// - enable unmasks, disable masks, mask readable
// - no interrupts for output or hardware pins
// - only unmasked interrupts reach the request
`timescale 1ns/1ps
`include "gpdr_params.svh"
module gpdr_port_regs (
  // Clock, reset and clock enable
  input logic core_clk,
  input logic rst_n,
  input logic ce,
  // AXI4-Lite write address and data
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_awaddr,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  input logic [31:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Pins, port index major
  input logic [3:0][15:0] padIn,
  output logic [3:0][15:0] padOut,
  output logic [3:0][15:0] padOeN,
  // Interrupt request per port
  output logic [3:0] irqReq
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] laneMask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++)
    begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

  function automatic logic regionHit(input logic [31:0] addr);
    return (addr & `GPDR_REGION_MASK) == `GPDR_BASE;
  endfunction

  // Slot of a plain storage register: bit 3 flags a hit.
  function automatic logic [3:0] cfgSlot(input logic [7:0] off);
    case (off)
      `GPDR_OFF_DEBOUNCE: cfgSlot = 4'h8;
      `GPDR_OFF_POLARITY: cfgSlot = 4'h9;
      `GPDR_OFF_SENSE: cfgSlot = 4'hA;
      `GPDR_OFF_PULL: cfgSlot = 4'hB;
      `GPDR_OFF_OTYPE: cfgSlot = 4'hC;
      `GPDR_OFF_AF_LOW: cfgSlot = 4'hD;
      `GPDR_OFF_AF_HIGH: cfgSlot = 4'hE;
      `GPDR_OFF_ADC_TRIG: cfgSlot = 4'hF;
      default: cfgSlot = 4'h0;
    endcase
  endfunction

  function automatic logic [31:0] cfgWmask(input logic [2:0] idx);
    case (idx)
      3'h0: cfgWmask = `GPDR_DEBOUNCE_WMASK;
      3'h2: cfgWmask = `GPDR_SENSE_WMASK;
      default: cfgWmask = `GPDR_FULL_WMASK;
    endcase
  endfunction

  // A pin with a nonzero alternate function field is under hardware control.
  function automatic logic [15:0] pinHw(input logic [31:0] afl,
                                        input logic [31:0] afh);
    logic [15:0] hw;
    hw = 16'h0000;
    for (int i = 0; i < 8; i++)
    begin
      hw[i] = |afl[i*4 +: 4];
      hw[i+8] = |afh[i*4 +: 4];
    end
    return hw;
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  gpdr_pkg::gpdr_wreq_t pend_ff;
  logic [3:0][15:0] portData_ff;
  logic [3:0][15:0] portDir_ff;
  logic [3:0][15:0] irqMask_ff;
  logic [3:0][15:0] irqRaw_ff;
  logic [3:0][7:0][31:0] cfg_ff;
  logic [3:0][15:0] syncA_ff;
  logic [3:0][15:0] syncB_ff;
  logic [3:0][15:0] syncC_ff;
  logic [3:0] irqReq_ff;

  logic [3:0][15:0] nxt_portData;
  logic [3:0][15:0] nxt_portDir;
  logic [3:0][15:0] nxt_irqMask;
  logic [3:0][15:0] nxt_irqRaw;
  logic [3:0][7:0][31:0] nxt_cfg;
  logic [3:0][15:0] pinEvent;
  logic [31:0] rdWord;
  logic rdHit;

  logic wrFire;
  logic wrHit;
  logic [1:0] wrPort;
  logic [7:0] wrOff;
  logic [31:0] wrMask;
  logic [31:0] wrBits;
  logic [15:0] setBits;
  logic [15:0] clrBits;
  logic [3:0] cfgW;
  logic [1:0] rdPort;
  logic [7:0] rdOff;
  logic [3:0] cfgR;

  // A write fires once both halves are held and no response is pending.
  assign wrFire = ce && !awready_ff && !wready_ff && !bvalid_ff;
  assign wrHit = regionHit(pend_ff.addr);
  assign wrPort = pend_ff.addr[`GPDR_PORT_LSB +: 2];
  assign wrOff = pend_ff.addr[7:0];
  assign wrMask = laneMask(pend_ff.strb);
  assign wrBits = pend_ff.data & wrMask;
  assign setBits = wrBits[15:0];
  assign clrBits = wrBits[31:16];
  assign cfgW = cfgSlot(wrOff);
  assign rdPort = s_axi_araddr[`GPDR_PORT_LSB +: 2];
  assign rdOff = s_axi_araddr[7:0];
  assign cfgR = cfgSlot(rdOff);

  // ************************************************************
  // Next state of the port registers
  // ************************************************************
  always_comb
  begin
    logic sel;
    logic [15:0] hw;
    logic [15:0] nowIn;
    logic [15:0] oldIn;
    logic [31:0] pol;
    logic [15:0] lvl;
    sel = 1'b0;
    hw = 16'h0000;
    nowIn = 16'h0000;
    oldIn = 16'h0000;
    pol = 32'h0000_0000;
    lvl = 16'h0000;
    for (int p = 0; p < 4; p++)
    begin
      sel = wrFire && wrHit && (wrPort == 2'(p));
      nxt_portData[p] = portData_ff[p];
      nxt_portDir[p] = portDir_ff[p];
      nxt_irqMask[p] = irqMask_ff[p];
      nxt_cfg[p] = cfg_ff[p];
      if (sel)
      begin
        case (wrOff)
          `GPDR_OFF_DATA:
            nxt_portData[p] = (portData_ff[p] & ~wrMask[15:0]) |
                              wrBits[15:0];
          `GPDR_OFF_DIR:
            nxt_portDir[p] = (portDir_ff[p] & ~wrMask[15:0]) |
                             wrBits[15:0];
          // The pulse lives only in this cycle, so nothing is stored.
          `GPDR_OFF_SETCLR:
            nxt_portData[p] = (portData_ff[p] | setBits) &
                              ~clrBits;
          `GPDR_OFF_IRQ_EN:
            nxt_irqMask[p] = irqMask_ff[p] | setBits;
          `GPDR_OFF_IRQ_DIS:
            nxt_irqMask[p] = irqMask_ff[p] & ~setBits;
          default:
            if (cfgW[3])
            begin
              nxt_cfg[p][cfgW[2:0]] =
                (cfg_ff[p][cfgW[2:0]] & ~(wrMask & cfgWmask(cfgW[2:0]))) |
                (wrBits & cfgWmask(cfgW[2:0]));
            end
        endcase
      end
      // Edge and level detection on the synchronised, filtered-free input.
      hw = pinHw(cfg_ff[p][5], cfg_ff[p][6]);
      nowIn = syncB_ff[p];
      oldIn = syncC_ff[p];
      pol = cfg_ff[p][1];
      lvl = cfg_ff[p][2][15:0];
      pinEvent[p] = 16'h0000;
      for (int i = 0; i < 16; i++)
      begin
        if (lvl[i])
          pinEvent[p][i] = nowIn[i] == pol[i];
        else if (pol[i+16])
          pinEvent[p][i] = nowIn[i] ^ oldIn[i];
        else if (pol[i])
          pinEvent[p][i] = nowIn[i] & ~oldIn[i];
        else
          pinEvent[p][i] = ~nowIn[i] & oldIn[i];
      end
      pinEvent[p] = pinEvent[p] & portDir_ff[p] & ~hw;
      // A new event wins over a clear in the same cycle.
      nxt_irqRaw[p] = irqRaw_ff[p];
      if (sel && wrOff == `GPDR_OFF_MSK_CLR)
        nxt_irqRaw[p] = irqRaw_ff[p] & ~setBits;
      nxt_irqRaw[p] = nxt_irqRaw[p] | pinEvent[p];
    end
  end

  // ************************************************************
  // Read multiplexer
  // ************************************************************
  always_comb
  begin
    rdWord = 32'h0000_0000;
    rdHit = regionHit(s_axi_araddr);
    if (rdHit)
    begin
      case (rdOff)
        `GPDR_OFF_DATA:
          rdWord = {16'h0000, (portDir_ff[rdPort] & syncB_ff[rdPort]) |
                   (~portDir_ff[rdPort] & portData_ff[rdPort])};
        `GPDR_OFF_DIR:
          rdWord = {16'h0000, portDir_ff[rdPort]};
        `GPDR_OFF_MASK_STAT:
          rdWord = {16'h0000, irqMask_ff[rdPort]};
        `GPDR_OFF_RAW_STAT:
          rdWord = {16'h0000, irqRaw_ff[rdPort]};
        `GPDR_OFF_MSK_CLR:
          rdWord = {16'h0000, irqRaw_ff[rdPort] & irqMask_ff[rdPort]};
        default:
          // Write-only and unassigned offsets fall here and read zero.
          if (cfgR[3])
            rdWord = cfg_ff[rdPort][cfgR[2:0]];
      endcase
    end
  end

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= `GPDR_RESP_OKAY;
      pend_ff <= '0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && awready_ff)
      begin
        pend_ff.addr <= s_axi_awaddr;
        awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff)
      begin
        pend_ff.data <= s_axi_wdata;
        pend_ff.strb <= s_axi_wstrb;
        wready_ff <= 1'b0;
      end
      if (wrFire)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wrHit ? `GPDR_RESP_OKAY : `GPDR_RESP_DECERR;
      end
      if (bvalid_ff && s_axi_bready)
      begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `GPDR_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && arready_ff)
      begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= rdWord;
        rresp_ff <= rdHit ? `GPDR_RESP_OKAY : `GPDR_RESP_DECERR;
      end
      if (rvalid_ff && s_axi_rready)
      begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Pin data and direction
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      portData_ff <= {4{`GPDR_DATA_RST}};
      portDir_ff <= {4{`GPDR_DIR_RST}};
    end
    else if (ce)
    begin
      portData_ff <= nxt_portData;
      portDir_ff <= nxt_portDir;
    end
  end

  // ************************************************************
  // Interrupt mask, status and request
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      irqMask_ff <= '0;
      irqRaw_ff <= '0;
      irqReq_ff <= 4'h0;
    end
    else if (ce)
    begin
      irqMask_ff <= nxt_irqMask;
      irqRaw_ff <= nxt_irqRaw;
      for (int p = 0; p < 4; p++)
      begin
        irqReq_ff[p] <= |(nxt_irqRaw[p] & nxt_irqMask[p]);
      end
    end
  end

  // ************************************************************
  // Storage registers and input synchronisers
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      cfg_ff <= {32{`GPDR_CFG_RST}};
    else if (ce)
      cfg_ff <= nxt_cfg;
  end

  // Pins are asynchronous; the third stage only serves edge detection.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      syncA_ff <= '0;
      syncB_ff <= '0;
      syncC_ff <= '0;
    end
    else if (ce)
    begin
      syncA_ff <= padIn;
      syncB_ff <= syncA_ff;
      syncC_ff <= syncB_ff;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign padOut = portData_ff;
  assign padOeN = portDir_ff;
  assign irqReq = irqReq_ff;

  // ************************************************************
  // Checks
  // ************************************************************
  logic [15:0] srtSet0;
  logic [15:0] srtClr0;
  logic wrSel0;
  assign wrSel0 = wrFire && wrHit && wrPort == 2'h0;
  assign srtSet0 = (wrSel0 && wrOff == `GPDR_OFF_SETCLR) ?
                   (setBits & ~clrBits) : 16'h0000;
  assign srtClr0 = (wrSel0 && wrOff == `GPDR_OFF_SETCLR) ?
                   clrBits : 16'h0000;

  property p_reset_vals;
    @(posedge core_clk)
    $rose(rst_n) |-> (portData_ff[0] == 16'hFFFF &&
                      portDir_ff[3] == 16'hFFFF && irqMask_ff[1] == 16'h0);
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("Port registers left reset with wrong values.");

  property p_set_bits;
    @(posedge core_clk) disable iff (!rst_n)
    srtSet0 != 16'h0000 |=>
      (portData_ff[0] & $past(srtSet0)) == $past(srtSet0);
  endproperty
  a_set_bits: assert property (p_set_bits)
    else $error("Set pulse did not raise data bits.");

  property p_clr_bits;
    @(posedge core_clk) disable iff (!rst_n)
    srtClr0 != 16'h0000 |=> (portData_ff[0] & $past(srtClr0)) == 16'h0000;
  endproperty
  a_clr_bits: assert property (p_clr_bits)
    else $error("Clear pulse did not lower data bits.");

  property p_keep_bits;
    @(posedge core_clk) disable iff (!rst_n)
    (wrSel0 && wrOff == `GPDR_OFF_SETCLR) |=>
      ((portData_ff[0] ^ $past(portData_ff[0])) &
       ~($past(srtSet0) | $past(srtClr0))) == 16'h0000;
  endproperty
  a_keep_bits: assert property (p_keep_bits)
    else $error("Set/clear touched unselected data bits.");

  property p_dir_pins;
    @(posedge core_clk) disable iff (!rst_n)
    (wrSel0 && wrOff == `GPDR_OFF_DIR && wrMask[15:0] == 16'hFFFF) |=>
      padOeN[0] == $past(wrBits[15:0]);
  endproperty
  a_dir_pins: assert property (p_dir_pins)
    else $error("Direction write not on pin enables next cycle.");

  property p_upper_zero;
    @(posedge core_clk) disable iff (!rst_n)
    (s_axi_arvalid && arready_ff && ce &&
     (rdOff == `GPDR_OFF_DATA || rdOff == `GPDR_OFF_DIR)) |=>
      rdata_ff[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("Reserved upper bits read nonzero.");

  property p_wo_zero;
    @(posedge core_clk) disable iff (!rst_n)
    (s_axi_arvalid && arready_ff && ce && (rdOff == `GPDR_OFF_SETCLR ||
     rdOff == `GPDR_OFF_IRQ_EN || rdOff == `GPDR_OFF_IRQ_DIS)) |=>
      (rvalid_ff && rdata_ff == 32'h0000_0000);
  endproperty
  a_wo_zero: assert property (p_wo_zero)
    else $error("Write-only register read nonzero.");

  property p_enable_mask;
    @(posedge core_clk) disable iff (!rst_n)
    (wrSel0 && wrOff == `GPDR_OFF_IRQ_EN) |=>
      (irqMask_ff[0] & $past(setBits)) == $past(setBits);
  endproperty
  a_enable_mask: assert property (p_enable_mask)
    else $error("Enable write did not unmask.");

  property p_no_out_irq;
    @(posedge core_clk) disable iff (!rst_n)
    ((irqRaw_ff[0] & ~$past(irqRaw_ff[0])) & ~$past(portDir_ff[0])) == 16'h0;
  endproperty
  a_no_out_irq: assert property (p_no_out_irq)
    else $error("Output pin raised an interrupt.");

  property p_irq_req;
    @(posedge core_clk) disable iff (!rst_n)
    irqReq_ff[0] == |(irqRaw_ff[0] & irqMask_ff[0]);
  endproperty
  a_irq_req: assert property (p_irq_req)
    else $error("Interrupt request disagrees with masked status.");

endmodule

// ==== tb/gpdr_pin_model.sv ====
// Pin-side model of the four GPIO ports that face the register block.
`timescale 1ns/1ps
module gpdr_pin_model (
  // Device side of each pin
  input wire logic [3:0][15:0] padOut,
  input wire logic [3:0][15:0] padOeN,
  // External drivers and resolved pin levels
  input wire logic [3:0][15:0] extDrive,
  output logic [3:0][15:0] padIn
);
  // ********************
  // Pin resolution
  // ********************
  // The external driver yields wherever the device drives the pin, so the
  // level seen on an output pin is always the device's own value.
  assign padIn = (padOut & ~padOeN) | (extDrive & padOeN);
endmodule

// ==== tb/tb_gpdr_port_regs.sv ====
// Self-checking bench for the four-port GPIO register block.
`timescale 1ns/1ps
`include "gpdr_params.svh"
module tb_gpdr_port_regs;
  // ********************
  // Signals
  // ********************
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic awValid = 1'b0;
  logic awReady;
  logic [31:0] awAddr = 32'h0000_0000;
  logic wValid = 1'b0;
  logic wReady;
  logic [31:0] wData = 32'h0000_0000;
  logic [3:0] wStrb = 4'hF;
  logic bValid;
  logic bReady = 1'b0;
  logic [1:0] bResp;
  logic arValid = 1'b0;
  logic arReady;
  logic [31:0] arAddr = 32'h0000_0000;
  logic rValid;
  logic rReady = 1'b0;
  logic [31:0] rData;
  logic [1:0] rResp;
  logic [3:0][15:0] padIn;
  logic [3:0][15:0] padOut;
  logic [3:0][15:0] padOeN;
  logic [3:0] irqReq;
  logic [3:0][15:0] extDrive = {4{16'hFFFF}};
  logic [31:0] seed = 32'h0000_C2CB;
  int fails = 0;
  int totalChecks = 0;

  always #5 core_clk = ~core_clk;

  gpdr_port_regs i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_awaddr(awAddr), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_bresp(bResp), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_araddr(arAddr), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .padIn(padIn), .padOut(padOut), .padOeN(padOeN), .irqReq(irqReq)
  );

  gpdr_pin_model i_pins (
    .padOut(padOut), .padOeN(padOeN), .extDrive(extDrive), .padIn(padIn)
  );

  // ********************
  // Helpers
  // ********************
  function automatic logic [31:0] xs();
    logic [31:0] s;
    s = seed;
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    seed = s;
    return s;
  endfunction

  function automatic logic [31:0] ra(input int p, input logic [7:0] off);
    return 32'h5002_0000 + 32'(p) * 32'h0000_0100 + {24'h00, off};
  endfunction

  task automatic completeRun();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Both halves are offered together; each is dropped once it is taken.
  task automatic axiWrite(input logic [31:0] a, input logic [31:0] d,
                          input logic [1:0] er);
    int n;
    logic aDone;
    logic wDone;
    aDone = 1'b0;
    wDone = 1'b0;
    @(posedge core_clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge core_clk);
      if (!aDone && awReady)
      begin
        aDone = 1'b1;
        awValid <= 1'b0;
      end
      if (!wDone && wReady)
      begin
        wDone = 1'b1;
        wValid <= 1'b0;
      end
      if (bValid)
      begin
        chk("bresp", {30'h0, bResp}, {30'h0, er});
        bReady <= 1'b0;
        break;
      end
    end
    if (n == 64)
    begin
      fails++;
      completeRun();
    end
  endtask

  task automatic axiRead(input logic [31:0] a, input logic [31:0] ed,
                         input logic [1:0] er);
    int n;
    logic aDone;
    aDone = 1'b0;
    @(posedge core_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge core_clk);
      if (!aDone && arReady)
      begin
        aDone = 1'b1;
        arValid <= 1'b0;
      end
      if (rValid)
      begin
        chk("rdata", rData, ed);
        chk("rresp", {30'h0, rResp}, {30'h0, er});
        rReady <= 1'b0;
        break;
      end
    end
    if (n == 64)
    begin
      fails++;
      completeRun();
    end
  endtask

  // ********************
  // Main sequence
  // ********************
  initial
  begin
    int p;
    logic [31:0] dv, wv, e, sc;
    logic [15:0] ex;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    for (p = 0; p < 4; p++)
    begin
      chk("padOut", {16'h0, padOut[p]}, 32'h0000_FFFF);
      chk("padOeN", {16'h0, padOeN[p]}, 32'h0000_FFFF);
    end
    chk("irqReq", {28'h0, irqReq}, 32'h0000_0000);
    // Input pins read through two flops, so let them fill first.
    repeat (2) @(posedge core_clk);
    // Every offset of every port, the unassigned one included.
    for (int k = 0; k < 68; k++)
      axiRead(ra(k / 17, 8'((k % 17) * 4)), (k % 17 < 2) ? 32'h0000_FFFF :
              32'h0000_0000, `GPDR_RESP_OKAY);
    for (int i = 0; i < 16; i++)
    begin
      p = i % 4;
      dv = xs();
      wv = xs();
      e = xs();
      sc = (i < 4) ? 32'hFFFF_FFFF : xs();
      extDrive[p] <= e[15:0];
      axiWrite(ra(p, `GPDR_OFF_DIR), dv, `GPDR_RESP_OKAY);
      axiWrite(ra(p, `GPDR_OFF_DATA), wv, `GPDR_RESP_OKAY);
      chk("padOeN", {16'h0, padOeN[p]}, {16'h0, dv[15:0]});
      chk("padOut", {16'h0, padOut[p]}, {16'h0, wv[15:0]});
      axiRead(ra(p, `GPDR_OFF_DIR), {16'h0, dv[15:0]},
              `GPDR_RESP_OKAY);
      ex = (wv[15:0] & ~dv[15:0]) | (e[15:0] & dv[15:0]);
      axiRead(ra(p, `GPDR_OFF_DATA), {16'h0, ex}, `GPDR_RESP_OKAY);
      ex = (wv[15:0] | sc[15:0]) & ~sc[31:16];
      axiWrite(ra(p, `GPDR_OFF_SETCLR), sc, `GPDR_RESP_OKAY);
      chk("padOut", {16'h0, padOut[p]}, {16'h0, ex});
      axiWrite(ra(p, `GPDR_OFF_SETCLR), 32'h0000_0000, `GPDR_RESP_OKAY);
      chk("padOut", {16'h0, padOut[p]}, {16'h0, ex});
      axiRead(ra(p, `GPDR_OFF_SETCLR), 32'h0, `GPDR_RESP_OKAY);
    end
    axiWrite(32'h5002_0400, xs(), `GPDR_RESP_DECERR);
    axiRead(32'h5002_0400, 32'h0, `GPDR_RESP_DECERR);
    axiWrite(ra(0, 8'h2C), 32'hFFFF_FFFF, `GPDR_RESP_OKAY);
    axiRead(ra(0, 8'h2C), 32'h0, `GPDR_RESP_OKAY);
    // Interrupts on pin 0 of the first port; falling edge by default.
    extDrive[0] <= 16'hFFFF;
    axiWrite(ra(0, `GPDR_OFF_DIR), 32'h0000_FFFF, `GPDR_RESP_OKAY);
    axiWrite(ra(0, `GPDR_OFF_MSK_CLR), 32'hFFFF_FFFF, `GPDR_RESP_OKAY);
    axiWrite(ra(0, `GPDR_OFF_RAW_STAT), 32'hFFFF_FFFF, `GPDR_RESP_OKAY);
    axiWrite(ra(0, `GPDR_OFF_MASK_STAT), 32'hFFFF_FFFF, `GPDR_RESP_OKAY);
    axiRead(ra(0, `GPDR_OFF_RAW_STAT), 32'h0, `GPDR_RESP_OKAY);
    axiRead(ra(0, `GPDR_OFF_MASK_STAT), 32'h0, `GPDR_RESP_OKAY);
    axiWrite(ra(0, `GPDR_OFF_IRQ_EN), 32'h1, `GPDR_RESP_OKAY);
    axiRead(ra(0, `GPDR_OFF_MASK_STAT), 32'h1, `GPDR_RESP_OKAY);
    axiRead(ra(0, `GPDR_OFF_IRQ_EN), 32'h0, `GPDR_RESP_OKAY);
    extDrive[0] <= 16'hFFFE;
    repeat (8) @(posedge core_clk);
    chk("irqReq", {31'h0, irqReq[0]}, 32'h1);
    axiRead(ra(0, `GPDR_OFF_RAW_STAT), 32'h1, `GPDR_RESP_OKAY);
    axiRead(ra(0, `GPDR_OFF_MSK_CLR), 32'h1, `GPDR_RESP_OKAY);
    axiWrite(ra(0, `GPDR_OFF_MSK_CLR), 32'h1, `GPDR_RESP_OKAY);
    axiRead(ra(0, `GPDR_OFF_RAW_STAT), 32'h0, `GPDR_RESP_OKAY);
    chk("irqReq", {31'h0, irqReq[0]}, 32'h0);
    axiWrite(ra(0, `GPDR_OFF_IRQ_DIS), 32'h1, `GPDR_RESP_OKAY);
    axiRead(ra(0, `GPDR_OFF_MASK_STAT), 32'h0, `GPDR_RESP_OKAY);
    axiRead(ra(0, `GPDR_OFF_IRQ_DIS), 32'h0, `GPDR_RESP_OKAY);
    extDrive[0] <= 16'hFFFF;
    repeat (6) @(posedge core_clk);
    extDrive[0] <= 16'hFFFE;
    repeat (8) @(posedge core_clk);
    axiRead(ra(0, `GPDR_OFF_RAW_STAT), 32'h1, `GPDR_RESP_OKAY);
    axiRead(ra(0, `GPDR_OFF_MSK_CLR), 32'h0, `GPDR_RESP_OKAY);
    chk("irqReq", {31'h0, irqReq[0]}, 32'h0);
    // An output pin toggled by its own data must not raise status.
    axiWrite(ra(0, `GPDR_OFF_DIR), 32'h0000_FFFE, `GPDR_RESP_OKAY);
    axiWrite(ra(0, `GPDR_OFF_MSK_CLR), 32'h1, `GPDR_RESP_OKAY);
    axiWrite(ra(0, `GPDR_OFF_IRQ_EN), 32'h1, `GPDR_RESP_OKAY);
    axiWrite(ra(0, `GPDR_OFF_SETCLR), 32'h0000_0001, `GPDR_RESP_OKAY);
    axiWrite(ra(0, `GPDR_OFF_SETCLR), 32'h0001_0000, `GPDR_RESP_OKAY);
    repeat (8) @(posedge core_clk);
    axiRead(ra(0, `GPDR_OFF_RAW_STAT), 32'h0, `GPDR_RESP_OKAY);
    chk("irqReq", {31'h0, irqReq[0]}, 32'h0);
    // A pin under a hardware function stays quiet; a free input does not.
    axiWrite(ra(0, `GPDR_OFF_DIR), 32'h0000_FFFF, `GPDR_RESP_OKAY);
    axiWrite(ra(0, `GPDR_OFF_AF_LOW), 32'h0000_0003, `GPDR_RESP_OKAY);
    axiWrite(ra(0, `GPDR_OFF_MSK_CLR), 32'h1, `GPDR_RESP_OKAY);
    extDrive[0] <= 16'hFFFF;
    repeat (6) @(posedge core_clk);
    extDrive[0] <= 16'hFFFE;
    repeat (8) @(posedge core_clk);
    axiRead(ra(0, `GPDR_OFF_RAW_STAT), 32'h0, `GPDR_RESP_OKAY);
    axiWrite(ra(0, `GPDR_OFF_AF_LOW), 32'h0, `GPDR_RESP_OKAY);
    axiWrite(ra(0, `GPDR_OFF_POLARITY), 32'h1, `GPDR_RESP_OKAY);
    extDrive[0] <= 16'hFFFF;
    repeat (8) @(posedge core_clk);
    axiRead(ra(0, `GPDR_OFF_RAW_STAT), 32'h1, `GPDR_RESP_OKAY);
    chk("irqReq", {31'h0, irqReq[0]}, 32'h1);
    completeRun();
  end
endmodule
